// ===== hdl/ecsi_channel.sv
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module ecsi_channel #(
  parameter int LOS_ZEROS = ecsi_pkg::ECSI_LOS_ZEROS,
  parameter int EXTENDED_SIGNAL_LOSS_ZEROS = ecsi_pkg::ECSI_EXTENDED_SIGNAL_LOSS_ZEROS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire ecsi_pkg::ecsi_tx_pins_t tx_pins,
  input wire logic tx_all_ones_force,
  output ecsi_pkg::ecsi_rail_t line_tx,
  input wire ecsi_pkg::ecsi_rail_t line_rx,
  input wire logic line_rx_clk,
  output ecsi_pkg::ecsi_rx_pins_t rx_pins
);
  import ecsi_pkg::*;

  localparam int CW = $clog2(EXTENDED_SIGNAL_LOSS_ZEROS + 1);
  localparam int HW = $clog2(ECSI_AOS_HALF + 1);

  // Bus slave state.
  logic [4:0] ctrl_q, ctrl_d;
  logic wpend_q, wpend_d;
  logic [7:0] waddr_q, waddr_d;
  logic [31:0] rdata_q, rdata_d;
  logic aos_pin_s;
  logic [2:0] tx_s, rx_s;
  logic tx_rise, rx_rise;
  logic single_m, hdb3_m, aos_on, extended_signal_loss_m;

  assign single_m = ctrl_q[ECSI_CTRL_SINGLE];
  assign hdb3_m = ctrl_q[ECSI_CTRL_HDB3];
  assign extended_signal_loss_m = ctrl_q[ECSI_CTRL_EXTENDED_SIGNAL_LOSS];
  // Host mode uses the register bit only, so the pin may float.
  assign aos_on = ctrl_q[ECSI_CTRL_HOST] ? ctrl_q[ECSI_CTRL_AOS] : aos_pin_s;

  // Transmit clock plus rails, and receive clock plus rails, cross in through two flops.
  ecsi_edge_sync #(.W(3)) u_tx_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({tx_pins.neg, tx_pins.pos, tx_pins.clk}),
    .sync_out(tx_s),
    .rise_out(tx_rise)
  );
  ecsi_edge_sync #(.W(3)) u_rx_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({line_rx.n, line_rx.p, line_rx_clk}),
    .sync_out(rx_s),
    .rise_out(rx_rise)
  );
  ecsi_edge_sync #(.W(1)) u_aos_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(tx_all_ones_force),
    .sync_out(aos_pin_s),
    .rise_out()
  );

  // Register writes complete in the data phase; reads answer with zero wait states.
  always_comb begin
    ctrl_d = ctrl_q;
    wpend_d = 1'b0;
    waddr_d = waddr_q;
    rdata_d = rdata_q;
    if (wpend_q && waddr_q == ECSI_OFF_CTRL) begin
      ctrl_d = hwdata[4:0];
    end
    if (hsel && hready && htrans[1]) begin
      wpend_d = hwrite;
      waddr_d = haddr[7:0];
      rdata_d = 32'h0000_0000;
      if (!hwrite && haddr[7:0] == ECSI_OFF_CTRL) begin
        rdata_d = {{27{1'b0}}, ctrl_q};
      end else if (!hwrite && haddr[7:0] == ECSI_OFF_STAT) begin
        rdata_d = {{30{1'b0}}, aos_on, rx_pins.signal_loss_flag};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= ECSI_CTRL_RST;
      wpend_q <= 1'b0;
      waddr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      wpend_q <= wpend_d;
      waddr_q <= waddr_d;
      rdata_q <= rdata_d;
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Transmit encoder state.
  logic ami_pol_q, ami_pol_d;
  logic [1:0] zcnt_q, zcnt_d;
  logic [3:0] dly_q, dly_d;
  logic lastv_q, lastv_d;
  logic [3:0] pend_q, pend_d;
  logic [3:0] pendp_q, pendp_d;
  ecsi_rail_t out_q, out_d;
  logic [HW-1:0] hcnt_q, hcnt_d;
  logic aph_q, aph_d;

  // HDB3 looks four bits ahead: data ride a 4-stage delay, marks are decided at the tail.
  always_comb begin
    ami_pol_d = ami_pol_q;
    zcnt_d = zcnt_q;
    dly_d = dly_q;
    lastv_d = lastv_q;
    pend_d = pend_q;
    pendp_d = pendp_q;
    out_d = out_q;
    hcnt_d = hcnt_q;
    aph_d = aph_q;
    if (aos_on) begin
      // All ones paced by the master clock, alternating marks each bit.
      if (hcnt_q == HW'(ECSI_AOS_HALF - 1)) begin
        hcnt_d = '0;
        aph_d = ~aph_q;
        if (!aph_q) begin
          ami_pol_d = ~ami_pol_q;
          out_d = ami_pol_q ? '{p: 1'b0, n: 1'b1} : '{p: 1'b1, n: 1'b0};
        end
      end else begin
        hcnt_d = hcnt_q + HW'(1);
      end
    end else if (tx_rise) begin
      if (!single_m) begin
        out_d = '{p: tx_s[1], n: tx_s[2]};
      end else begin
        dly_d = {dly_q[2:0], tx_s[1]};
        zcnt_d = tx_s[1] ? 2'd0 : zcnt_q + 2'd1;
        pend_d = {pend_q[2:0], 1'b0};
        pendp_d = {pendp_q[2:0], 1'b0};
        // Tail bit: a substituted V repeats the last polarity; data ones and B marks alternate.
        if (pend_q[3] && pendp_q[3]) begin
          out_d = ami_pol_q ? '{p: 1'b1, n: 1'b0} : '{p: 1'b0, n: 1'b1};
          lastv_d = 1'b1;
        end else if (dly_q[3] || pend_q[3]) begin
          ami_pol_d = ~ami_pol_q;
          out_d = ami_pol_q ? '{p: 1'b0, n: 1'b1} : '{p: 1'b1, n: 1'b0};
          if (dly_q[3]) begin
            lastv_d = ~lastv_q;
          end
        end else begin
          out_d = '{p: 1'b0, n: 1'b0};
        end
        // Four zeros on entry become B00V after an even mark count, else 000V; the tail mark counts too.
        if (hdb3_m && !tx_s[1] && dly_q[2:0] == 3'b000 && pend_q[2:0] == 3'b000 && zcnt_q == 2'd3) begin
          pend_d = lastv_d ? 4'b1001 : 4'b0001;
          pendp_d = 4'b0001;
          lastv_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ami_pol_q <= 1'b0;
      zcnt_q <= 2'd0;
      dly_q <= 4'h0;
      lastv_q <= 1'b0;
      pend_q <= 4'h0;
      pendp_q <= 4'h0;
      out_q <= '0;
      hcnt_q <= '0;
      aph_q <= 1'b0;
    end else begin
      ami_pol_q <= ami_pol_d;
      zcnt_q <= zcnt_d;
      dly_q <= dly_d;
      lastv_q <= lastv_d;
      pend_q <= pend_d;
      pendp_q <= pendp_d;
      out_q <= out_d;
      hcnt_q <= hcnt_d;
      aph_q <= aph_d;
    end
  end

  assign line_tx = out_q;

  // Receive decoder state, advanced once per recovered clock edge.
  logic rlast_q, rlast_d;
  logic [CW-1:0] zrun_q, zrun_d;
  logic rx_positive_rail_out_q, rx_positive_rail_out_d, rx_negative_rail_out_q, rx_negative_rail_out_d, los_q, los_d;
  logic mark, vio;

  assign mark = rx_s[1] | rx_s[2];
  assign vio = mark && rx_s[1] == rlast_q;

  always_comb begin
    rlast_d = rlast_q;
    zrun_d = zrun_q;
    rx_positive_rail_out_d = rx_positive_rail_out_q;
    rx_negative_rail_out_d = rx_negative_rail_out_q;
    los_d = los_q;
    if (rx_rise) begin
      if (mark) begin
        rlast_d = rx_s[1];
        zrun_d = '0;
      end else if (zrun_q != CW'(EXTENDED_SIGNAL_LOSS_ZEROS)) begin
        zrun_d = zrun_q + CW'(1);
      end
      // Loss clears on the first mark, sets at the selected run length.
      los_d = extended_signal_loss_m ? (zrun_d >= CW'(EXTENDED_SIGNAL_LOSS_ZEROS)) : (zrun_d >= CW'(LOS_ZEROS));
      if (!single_m) begin
        rx_positive_rail_out_d = rx_s[1];
        rx_negative_rail_out_d = rx_s[2];
      end else begin
        // HDB3 violations are data zeros; AMI flags every violation.
        rx_positive_rail_out_d = mark && !(hdb3_m && vio);
        rx_negative_rail_out_d = hdb3_m ? 1'b0 : vio;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rlast_q <= 1'b0;
      zrun_q <= '0;
      rx_positive_rail_out_q <= 1'b0;
      rx_negative_rail_out_q <= 1'b0;
      los_q <= 1'b0;
    end else begin
      rlast_q <= rlast_d;
      zrun_q <= zrun_d;
      rx_positive_rail_out_q <= rx_positive_rail_out_d;
      rx_negative_rail_out_q <= rx_negative_rail_out_d;
      los_q <= los_d;
    end
  end

  // Recovered clock is the synchronised line clock, so outputs move just after its rise.
  assign rx_pins = '{clk: rx_s[0], pos: rx_positive_rail_out_q, neg: rx_negative_rail_out_q, signal_loss_flag: los_q};

  a_los_short: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_rise && !extended_signal_loss_m && zrun_d == CW'(LOS_ZEROS)) |=> rx_pins.signal_loss_flag)
    else $error("loss flag not set after short zero run");
  a_los_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_rise && mark) |=> !rx_pins.signal_loss_flag)
    else $error("loss flag not cleared by mark");
  a_los_ext: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_rise && extended_signal_loss_m && zrun_d < CW'(EXTENDED_SIGNAL_LOSS_ZEROS)) |=> !rx_pins.signal_loss_flag)
    else $error("extended loss set too early");
  a_vio_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_rise && single_m && !hdb3_m && vio) |=> rx_pins.neg)
    else $error("violation not flagged");
  a_dual_rail: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_rise && !single_m) |=> (rx_pins.pos == $past(rx_s[1]) && rx_pins.neg == $past(rx_s[2])))
    else $error("dual rail receive mismatch");
  a_nrz_out: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_rise && single_m && !mark) |=> !rx_pins.pos)
    else $error("nrz output not zero on space");
  a_vio_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (!rx_rise && single_m) |=> $stable(rx_pins.neg))
    else $error("receive output moved without clock edge");
  a_tx_dual: assert property (@(posedge hclk) disable iff (!hresetn)
    (tx_rise && !aos_on && !single_m) |=> (line_tx.p == $past(tx_s[1]) && line_tx.n == $past(tx_s[2])))
    else $error("dual rail transmit mismatch");
  a_aos_host: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctrl_q[ECSI_CTRL_HOST] && !ctrl_q[ECSI_CTRL_AOS] && !tx_rise) |=> $stable(line_tx))
    else $error("line moved in host mode without transmit clock");
  a_aos_ami: assert property (@(posedge hclk) disable iff (!hresetn)
    aos_on |-> !(line_tx.p && line_tx.n))
    else $error("both marks driven");
endmodule
`default_nettype wire

// ===== hdl/ecsi_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ecsi_edge_sync #(
  parameter int W = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out,
  output logic rise_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic prev_q;

  // Two-stage synchroniser; bit 0 is treated as a clock whose rising edge is reported.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      prev_q <= 1'b0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      prev_q <= s2_q[0];
    end
  end

  assign sync_out = s2_q;
  assign rise_out = s2_q[0] & ~prev_q;
endmodule
`default_nettype wire

// ===== hdl/ecsi_pkg.sv
package ecsi_pkg;

  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0] ECSI_OFF_CTRL = 8'h00;
  localparam logic [7:0] ECSI_OFF_STAT = 8'h04;

  // Control register field positions.
  localparam int ECSI_CTRL_SINGLE = 0;
  localparam int ECSI_CTRL_HDB3 = 1;
  localparam int ECSI_CTRL_AOS = 2;
  localparam int ECSI_CTRL_EXTENDED_SIGNAL_LOSS = 3;
  localparam int ECSI_CTRL_HOST = 4;
  localparam logic [4:0] ECSI_CTRL_RST = 5'h00;

  // Status register field positions.
  localparam int ECSI_STAT_LOS = 0;
  localparam int ECSI_STAT_AOS = 1;

  // Loss-of-signal zero counts.
  localparam int ECSI_LOS_ZEROS = 32;
  localparam int ECSI_EXTENDED_SIGNAL_LOSS_ZEROS = 4096;

  // All-ones timing from the master clock: half an E1 bit in hclk cycles.
  localparam int ECSI_CLK_MHZ_X1000 = 20000;
  localparam int ECSI_E1_KHZ = 2048;
  localparam int ECSI_AOS_HALF = ECSI_CLK_MHZ_X1000 / (2 * ECSI_E1_KHZ);

  // Transmit side pin group.
  typedef struct packed {
    logic clk;
    logic pos;
    logic neg;
  } ecsi_tx_pins_t;

  // Bipolar line pair, positive and negative marks.
  typedef struct packed {
    logic p;
    logic n;
  } ecsi_rail_t;

  // Receive side pin group, all synchronous to rx clock.
  typedef struct packed {
    logic clk;
    logic pos;
    logic neg;
    logic signal_loss_flag;
  } ecsi_rx_pins_t;

endpackage

// ===== sim/ecsi_framer_model.sv
`timescale 1ns/1ps
`default_nettype none
module ecsi_framer_model (
  input wire logic en,
  input wire logic pbit,
  input wire logic nbit,
  output var ecsi_pkg::ecsi_tx_pins_t tx_pins
);
  import ecsi_pkg::*;
  // Half of one E1 bit period in ns.
  localparam real HALF_NS = 244.140625;
  initial tx_pins = '0;
  // Clock runs only while enabled; idle data lines carry a changing pattern.
  always begin
    #(HALF_NS);
    tx_pins.clk = en ? ~tx_pins.clk : 1'b0;
    if (!en) begin
      tx_pins.pos = ~tx_pins.pos;
      tx_pins.neg = ~tx_pins.neg;
    end else if (!tx_pins.clk) begin
      tx_pins.pos = pbit;
      tx_pins.neg = nbit;
    end
  end
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ecsi_pkg::*;
  localparam int LZ = 8;
  localparam int XZ = 40;
  localparam int AB = 2 * ECSI_AOS_HALF;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic tx_all_ones_force = 1'b0;
  ecsi_tx_pins_t tx_pins;
  ecsi_rail_t line_tx;
  ecsi_rail_t line_rx = '0;
  logic line_rx_clk = 1'b0;
  ecsi_rx_pins_t rx_pins;
  logic fr_en = 1'b0;
  logic fr_p = 1'b0;
  logic fr_n = 1'b0;
  logic neg_q = 1'b0;
  logic [31:0] rd;
  int error_cnt = 0;
  int n_checks = 0;
  int vcnt = 0;
  int v0;
  int cp;
  int cn;
  int cv;
  ecsi_rail_t prev_tx = '0;
  ecsi_rail_t last_mark = '0;

  // The bus clock runs at 20 MHz.
  always #25 hclk = ~hclk;

  ecsi_channel #(.LOS_ZEROS(LZ), .EXTENDED_SIGNAL_LOSS_ZEROS(XZ)) DUT (.hclk(hclk), .hresetn(hresetn),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hsel(hsel),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .tx_pins(tx_pins), .tx_all_ones_force(tx_all_ones_force), .line_tx(line_tx),
    .line_rx(line_rx), .line_rx_clk(line_rx_clk), .rx_pins(rx_pins));

  ecsi_framer_model u_framer (.en(fr_en), .pbit(fr_p), .nbit(fr_n), .tx_pins(tx_pins));

  // Counts rising edges of the violation output.
  always @(posedge hclk) begin
    neg_q <= rx_pins.neg;
    if (rx_pins.neg === 1'b1 && neg_q === 1'b0) vcnt <= vcnt + 1;
  end

  // Compares words and single bits.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chkb(input logic got, input logic exp);
    chk({31'b0, got}, {31'b0, exp});
  endtask

  // One single AHB-Lite transfer; read data lands in rd.
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsel <= 1'b1;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chkb(hresp, 1'b0);
  endtask

  // One received line bit with its 400 ns line clock.
  task rx_bit(input logic p, input logic n);
    line_rx <= {p, n};
    repeat (2) @(posedge hclk);
    line_rx_clk <= 1'b1;
    repeat (4) @(posedge hclk);
    line_rx_clk <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask
  task zeros(input int k);
    repeat (k) rx_bit(1'b0, 1'b0);
  endtask

  // Counts cycles with each transmit mark high, and marks that repeat the last polarity.
  task mon(input int k);
    cp = 0;
    cn = 0;
    cv = 0;
    last_mark = '0;
    repeat (k) begin
      @(posedge hclk);
      if (line_tx.p === 1'b1) cp++;
      if (line_tx.n === 1'b1) cn++;
      if (line_tx !== prev_tx && (line_tx.p || line_tx.n)) begin
        if (line_tx === last_mark) cv++;
        last_mark = line_tx;
      end
      prev_tx = line_tx;
    end
  endtask

  // Reset values and an unmapped address.
  task t_reset;
    xfer(1'b0, ECSI_OFF_CTRL, '0);
    chk(rd, 32'h0000_0000);
    xfer(1'b0, ECSI_OFF_STAT, '0);
    chk(rd, 32'h0000_0000);
    xfer(1'b1, 32'h0000_0040, 32'hFFFF_FFFF);
    xfer(1'b0, 32'h0000_0040, '0);
    chk(rd, 32'h0000_0000);
    xfer(1'b0, ECSI_OFF_CTRL, '0);
    chk(rd, 32'h0000_0000);
  endtask

  // Dual-rail rails pass straight through.
  task t_dual_rx;
    rx_bit(1'b1, 1'b0);
    chk({30'b0, rx_pins.pos, rx_pins.neg}, 32'h0000_0002);
    rx_bit(1'b0, 1'b1);
    chk({30'b0, rx_pins.pos, rx_pins.neg}, 32'h0000_0001);
    line_rx_clk <= 1'b1;
    repeat (4) @(posedge hclk);
    chkb(rx_pins.clk, 1'b1);
    line_rx_clk <= 1'b0;
    repeat (4) @(posedge hclk);
    chkb(rx_pins.clk, 1'b0);
  endtask

  // Loss after the normal and the extended zero counts, cleared by a mark.
  task t_los;
    zeros(LZ - 1);
    chkb(rx_pins.signal_loss_flag, 1'b0);
    zeros(1);
    chkb(rx_pins.signal_loss_flag, 1'b1);
    xfer(1'b0, ECSI_OFF_STAT, '0);
    chkb(rd[ECSI_STAT_LOS], 1'b1);
    rx_bit(1'b1, 1'b0);
    chkb(rx_pins.signal_loss_flag, 1'b0);
    xfer(1'b1, ECSI_OFF_CTRL, 32'h0000_0008);
    zeros(XZ - 1);
    chkb(rx_pins.signal_loss_flag, 1'b0);
    zeros(1);
    chkb(rx_pins.signal_loss_flag, 1'b1);
    rx_bit(1'b0, 1'b1);
  endtask

  // Single-rail AMI decode with one bipolar violation.
  task t_single_rx;
    xfer(1'b1, ECSI_OFF_CTRL, 32'h0000_0001);
    rx_bit(1'b1, 1'b0);
    v0 = vcnt;
    rx_bit(1'b0, 1'b1);
    chkb(rx_pins.pos, 1'b1);
    zeros(1);
    chkb(rx_pins.pos, 1'b0);
    rx_bit(1'b0, 1'b1);
    chkb(rx_pins.neg, 1'b1);
    rx_bit(1'b1, 1'b0);
    chkb(rx_pins.neg, 1'b0);
    chk(vcnt - v0, 32'h0000_0001);
  endtask

  // Transmit in both rail modes and both codes.
  task t_tx;
    xfer(1'b1, ECSI_OFF_CTRL, 32'h0000_0000);
    fr_en <= 1'b1;
    fr_p <= 1'b1;
    repeat (100) @(posedge hclk);
    chk({30'b0, line_tx.p, line_tx.n}, 32'h0000_0002);
    fr_p <= 1'b0;
    fr_n <= 1'b1;
    repeat (100) @(posedge hclk);
    chk({30'b0, line_tx.p, line_tx.n}, 32'h0000_0001);
    fr_p <= 1'b1;
    fr_n <= 1'b0;
    xfer(1'b1, ECSI_OFF_CTRL, 32'h0000_0001);
    mon(200);
    chkb(cp > 0 && cn > 0, 1'b1);
    chk(cv, 32'h0000_0000);
    fr_p <= 1'b0;
    repeat (200) @(posedge hclk);
    mon(200);
    chk(cp + cn, 32'h0000_0000);
    xfer(1'b1, ECSI_OFF_CTRL, 32'h0000_0003);
    mon(400);
    chkb(cp > 0 && cn > 0, 1'b1);
    chkb(cv > 0, 1'b1);
    fr_en <= 1'b0;
  endtask

  // All-ones from the pin, ignored in host mode, then from the register.
  task t_aos;
    xfer(1'b1, ECSI_OFF_CTRL, 32'h0000_0000);
    tx_all_ones_force <= 1'b1;
    repeat (40) @(posedge hclk);
    mon(20 * AB);
    chk(cp, 10 * AB);
    chk(cn, 10 * AB);
    chk(cv, 32'h0000_0000);
    xfer(1'b0, ECSI_OFF_STAT, '0);
    chkb(rd[ECSI_STAT_AOS], 1'b1);
    xfer(1'b1, ECSI_OFF_CTRL, 32'h0000_0010);
    repeat (40) @(posedge hclk);
    mon(20 * AB);
    chkb(cp > 0 && cn > 0, 1'b0);
    xfer(1'b0, ECSI_OFF_STAT, '0);
    chkb(rd[ECSI_STAT_AOS], 1'b0);
    tx_all_ones_force <= 1'b0;
    xfer(1'b1, ECSI_OFF_CTRL, 32'h0000_0014);
    repeat (40) @(posedge hclk);
    mon(20 * AB);
    chk(cp, 10 * AB);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task print_verdict;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence after an eight-cycle reset.
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_dual_rx;
    t_los;
    t_single_rx;
    t_tx;
    t_aos;
    print_verdict;
  end

  // Cuts a hang short.
  initial begin
    #1_000_000;
    error_cnt++;
    print_verdict;
  end
endmodule
`default_nettype wire
